// File: core/ipus_pkg.sv
package ipus_pkg;

  // =====================================================================
  // sequencer states
  typedef enum logic [4:0]
  {
    ST_POR = 5'h01,
    ST_HOLD = 5'h02,
    ST_DELAY = 5'h04,
    ST_INIT = 5'h08,
    ST_USER = 5'h10
  } ipus_state_t;

  localparam ipus_state_t RST_STATE = ST_POR;

  // =====================================================================
  // timing: figures in their own units, cycle counts derived from the clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_POR_SHORT_MS = 12;
  localparam int T_POR_LONG_MS = 100;
  localparam int T_ADD_MS = 50;
  localparam int T_CONF_DONE_NS = 600;
  localparam int T_STATUS_FALL_NS = 800;
  localparam int T_STATUS_RISE_US = 100;
  // least times round up
  localparam int POR_SHORT_CYC = (T_POR_SHORT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_LONG_CYC = (T_POR_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_CYC = (T_ADD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC = (T_CONF_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest times round down
  localparam int STATUS_FALL_CYC = T_STATUS_FALL_NS / CLK_PERIOD_NS;
  localparam int STATUS_RISE_CYC = (T_STATUS_RISE_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 21;

  // =====================================================================
  // synchronised pin bundle: bit positions and values under reset
  localparam int SYNC_W = 6;
  localparam int IN_REINIT = 0;
  localparam int IN_CHAIN = 1;
  localparam int IN_PUD = 2;
  localparam int IN_SEL = 3;
  localparam int IN_DONE = 4;
  localparam int IN_STATUS = 5;
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h21;

  // =====================================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_RESTART_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DONE_BIT = 5;
  localparam int STAT_PULLUP_BIT = 6;
  localparam int STAT_USER_BIT = 7;
  localparam int STAT_REINIT_BIT = 8;
  localparam int STAT_MODE_BIT = 9;
  localparam int STAT_LINE_BIT = 10;

endpackage

// File: core/ipus_sync.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// two-stage synchroniser for a bundle of pin levels
module ipus_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic pclk, // oscillator clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // levels safe to use
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ipus_sync_state_t;

  ipus_sync_state_t state_r;
  ipus_sync_state_t state_nxt;

  // the first stage feeds only the second stage
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.s1 = d;
    state_nxt.s2 = state_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= '{s1: RST_VAL, s2: RST_VAL};
    else
      state_r <= state_nxt;
  end

  assign q = state_r.s2;

endmodule
`default_nettype wire

// File: core/ipus_sequencer.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// instant-on power-up sequencer
module ipus_sequencer
#(
  parameter bit DELAYED_MODE = 1'b0, // build-time choice of the extra delay
  parameter bit HAS_PULLUP_DISABLE = 1'b1, // variant owns a pull-up disable input
  parameter bit USER_IND_EN = 1'b1, // user-mode indicator kept from prototype
  parameter int unsigned POR_SHORT_CYC = ipus_pkg::POR_SHORT_CYC, // short power-on
  parameter int unsigned POR_LONG_CYC = ipus_pkg::POR_LONG_CYC, // long power-on
  parameter int unsigned DELAY_CYC = ipus_pkg::DELAY_CYC // extra delay length
)
(
  input wire logic pclk, // on-chip oscillator
  input wire logic presetn, // power-on trip, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic reinit_req_n, // reinitialize request, active low
  input wire logic chain_enable_in_n, // chain enable in, active low
  input wire logic weak_pullup_disable, // high turns pull-ups off
  input wire logic reset_delay_select, // long power-on delay when high
  input wire logic status_in, // status line level
  output logic status_out, // status line drive level
  output logic status_oe_n, // status line driven low when 0
  input wire logic done_in, // done line level
  output logic done_out, // done line drive level
  output logic done_oe_n, // done line driven low when 0
  output logic chain_enable_out_n, // chain enable out, active low
  output logic user_mode_ind, // user-mode indicator
  output logic pullup_en, // weak pull-ups on user pins
  output logic reg_reset, // user register reset
  output logic pll_init, // pll initialisation strobe level
  output logic io_enable // used i/o pins enabled
);

  localparam int CW = ipus_pkg::CNT_W;
  localparam int FALL_MAX = ipus_pkg::STATUS_FALL_CYC;
  localparam int RISE_MAX = ipus_pkg::STATUS_RISE_CYC;
  localparam logic [CW-1:0] POR_SHORT_LAST = CW'(POR_SHORT_CYC - 1);
  localparam logic [CW-1:0] POR_LONG_LAST = CW'(POR_LONG_CYC - 1);
  localparam logic [CW-1:0] DELAY_LAST = CW'(DELAY_CYC - 1);
  localparam logic [CW-1:0] INIT_LAST = CW'(ipus_pkg::INIT_CYC - 1);

  typedef struct packed {
    ipus_pkg::ipus_state_t st;
    logic [CW-1:0] cnt;
    logic soft_req;
    logic status_oe_n;
    logic done_oe_n;
    logic od_level;
    logic chain_out_n;
    logic user_ind;
    logic pullup_en;
    logic reg_reset;
    logic pll_init;
    logic io_en;
    logic [11:0] rise_wait;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ipus_seq_state_t;

  // power-on view: lines pulled low, pull-ups on, user logic in reset
  localparam ipus_seq_state_t SEQ_RST = '{
    st: ipus_pkg::RST_STATE,
    cnt: '0,
    soft_req: 1'b0,
    status_oe_n: 1'b0,
    done_oe_n: 1'b0,
    od_level: 1'b0,
    chain_out_n: 1'b1,
    user_ind: 1'b0,
    pullup_en: 1'b1,
    reg_reset: 1'b1,
    pll_init: 1'b0,
    io_en: 1'b0,
    rise_wait: 12'h000,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0
  };

  ipus_seq_state_t state_r;
  ipus_seq_state_t state_nxt;
  logic [ipus_pkg::SYNC_W-1:0] sync_q;

  // =====================================================================
  // pin synchronisers: every board pin is asynchronous to the oscillator
  ipus_sync
  #(
    .W(ipus_pkg::SYNC_W),
    .RST_VAL(ipus_pkg::SYNC_RST)
  )
  u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .d({status_in, done_in, reset_delay_select, weak_pullup_disable,
        chain_enable_in_n, reinit_req_n}),
    .q(sync_q)
  );

  // =====================================================================
  // sequencer, register slave and output decode
  always_comb
  begin
    logic rq_low;
    logic por_end;
    logic apb_access;
    logic apb_commit;
    logic [31:0] status_word;
    rq_low = !sync_q[ipus_pkg::IN_REINIT];
    por_end = 1'b0;
    apb_access = psel && penable && !state_r.pready;
    apb_commit = psel && penable && state_r.pready;
    status_word = 32'h0;
    state_nxt = state_r;

    // power-on length follows the delay select pin, whole oscillator cycles
    if (sync_q[ipus_pkg::IN_SEL])
      por_end = (state_r.cnt >= POR_LONG_LAST);
    else
      por_end = (state_r.cnt >= POR_SHORT_LAST);

    // state progression; no configuration load anywhere
    unique case (state_r.st)
      ipus_pkg::ST_POR:
      begin
        state_nxt.cnt = state_r.cnt + 1'b1;
        if (por_end)
        begin
          state_nxt.cnt = '0;
          if (rq_low)
            state_nxt.st = ipus_pkg::ST_HOLD;
          else if (DELAYED_MODE)
            state_nxt.st = ipus_pkg::ST_DELAY;
          else
            state_nxt.st = ipus_pkg::ST_INIT;
        end
      end
      ipus_pkg::ST_HOLD:
      begin
        state_nxt.cnt = '0;
        if (!rq_low)
          state_nxt.st = ipus_pkg::ST_INIT;
      end
      ipus_pkg::ST_DELAY:
      begin
        // counted on the oscillator alone
        state_nxt.cnt = state_r.cnt + 1'b1;
        if (state_r.cnt == DELAY_LAST)
        begin
          state_nxt.cnt = '0;
          state_nxt.st = ipus_pkg::ST_INIT;
        end
      end
      ipus_pkg::ST_INIT:
      begin
        state_nxt.cnt = state_r.cnt + 1'b1;
        if (state_r.cnt == INIT_LAST)
        begin
          state_nxt.cnt = '0;
          state_nxt.st = ipus_pkg::ST_USER;
        end
      end
      ipus_pkg::ST_USER:
      begin
        state_nxt.cnt = '0;
      end
    endcase

    // software restart: taken only once supplies and request are settled
    if (state_r.soft_req && (state_r.st == ipus_pkg::ST_INIT
        || state_r.st == ipus_pkg::ST_USER))
    begin
      state_nxt.soft_req = 1'b0;
      state_nxt.st = ipus_pkg::ST_INIT;
      state_nxt.cnt = '0;
    end

    // a low request after power-on always wins and parks the sequence
    if (rq_low && state_r.st != ipus_pkg::ST_POR)
    begin
      state_nxt.st = ipus_pkg::ST_HOLD;
      state_nxt.cnt = '0;
    end

    // cycles with status held low after the request was seen released; a wait
    // that long is counted rather than unrolled in the check below
    if (!state_r.status_oe_n && state_r.st != ipus_pkg::ST_POR
        && sync_q[ipus_pkg::IN_REINIT])
      state_nxt.rise_wait = state_r.rise_wait + 12'h001;
    else
      state_nxt.rise_wait = 12'h000;

    // apb: answer one cycle into the access phase
    status_word[ipus_pkg::STAT_STATE_LSB +: 5] = state_r.st;
    status_word[ipus_pkg::STAT_DONE_BIT] = state_r.done_oe_n;
    status_word[ipus_pkg::STAT_PULLUP_BIT] = state_r.pullup_en;
    status_word[ipus_pkg::STAT_USER_BIT] = state_r.user_ind;
    status_word[ipus_pkg::STAT_REINIT_BIT] = sync_q[ipus_pkg::IN_REINIT];
    status_word[ipus_pkg::STAT_MODE_BIT] = DELAYED_MODE;
    status_word[ipus_pkg::STAT_LINE_BIT] = sync_q[ipus_pkg::IN_STATUS];
    state_nxt.pready = apb_access;
    state_nxt.pslverr = 1'b0;
    if (apb_access)
    begin
      unique case (paddr)
        ipus_pkg::ADDR_CTRL:
          state_nxt.prdata = {31'h0, state_r.soft_req};
        ipus_pkg::ADDR_STATUS:
          state_nxt.prdata = status_word;
        default:
        begin
          state_nxt.prdata = 32'h0;
          state_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // a write lands on the ready edge; placed last so a set beats the clear
    if (apb_commit && pwrite && paddr == ipus_pkg::ADDR_CTRL
        && pwdata[ipus_pkg::CTRL_RESTART_BIT])
      state_nxt.soft_req = 1'b1;

    // outputs decoded from the next state so pins change with the state
    state_nxt.od_level = 1'b0;
    state_nxt.status_oe_n = !(state_nxt.st == ipus_pkg::ST_POR
                              || state_nxt.st == ipus_pkg::ST_HOLD);
    state_nxt.done_oe_n = (state_nxt.st == ipus_pkg::ST_USER);
    // chain out follows done only while the board keeps chain in low
    state_nxt.chain_out_n = !(state_nxt.st == ipus_pkg::ST_USER
                              && !sync_q[ipus_pkg::IN_CHAIN]);
    // indicator waits for the done line itself, not for our release of it
    state_nxt.user_ind = USER_IND_EN && state_nxt.st == ipus_pkg::ST_USER
                         && sync_q[ipus_pkg::IN_DONE];
    // pull-ups on until user mode unless disabled
    state_nxt.pullup_en = state_nxt.st != ipus_pkg::ST_USER
                          && !(HAS_PULLUP_DISABLE
                               && sync_q[ipus_pkg::IN_PUD]);
    // initialisation phase: registers held, plls started, pins enabled
    state_nxt.reg_reset = state_nxt.st != ipus_pkg::ST_USER;
    state_nxt.pll_init = state_nxt.st == ipus_pkg::ST_INIT;
    state_nxt.io_en = state_nxt.st == ipus_pkg::ST_INIT
                      || state_nxt.st == ipus_pkg::ST_USER;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= SEQ_RST;
    else
      state_r <= state_nxt;
  end

  // =====================================================================
  // outputs, each straight from its flip-flop
  assign prdata = state_r.prdata;
  assign pready = state_r.pready;
  assign pslverr = state_r.pslverr;
  assign status_out = state_r.od_level;
  assign status_oe_n = state_r.status_oe_n;
  assign done_out = state_r.od_level;
  assign done_oe_n = state_r.done_oe_n;
  assign chain_enable_out_n = state_r.chain_out_n;
  assign user_mode_ind = state_r.user_ind;
  assign pullup_en = state_r.pullup_en;
  assign reg_reset = state_r.reg_reset;
  assign pll_init = state_r.pll_init;
  assign io_enable = state_r.io_en;

  // =====================================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // status falls a bounded time after the request falls
  a_status_fall: assert property (
    $fell(reinit_req_n) |-> ##[1:FALL_MAX] !status_oe_n)
    else $error("status line not pulled low in time");

  // status released a bounded time after the request rises; the two
  // synchroniser edges lie outside the counter, so they come off the limit
  a_status_rise: assert property (
    int'(state_r.rise_wait) + 2 <= RISE_MAX)
    else $error("status line not released in time");

  // leaving power-on without delay goes straight to initialization or hold
  a_no_delay_path: assert property (
    (!DELAYED_MODE && state_r.st == ipus_pkg::ST_POR) ##1
    (state_r.st != ipus_pkg::ST_POR)
    |-> state_r.st inside {ipus_pkg::ST_INIT, ipus_pkg::ST_HOLD})
    else $error("no-delay mode left power-on to a wrong state");

  // the extra delay ends only on its last counted cycle
  a_delay_length: assert property (
    state_r.st == ipus_pkg::ST_DELAY && state_nxt.st == ipus_pkg::ST_INIT
    |-> state_r.cnt == DELAY_LAST)
    else $error("extra delay ended at the wrong count");

  // a low request keeps the sequence parked
  a_hold_parked: assert property (
    state_r.st == ipus_pkg::ST_HOLD && !sync_q[ipus_pkg::IN_REINIT]
    |=> state_r.st == ipus_pkg::ST_HOLD && !done_oe_n)
    else $error("initialization ran while the request was low");

  // chain out asserts with the release of done while chain in is low
  a_chain_with_done: assert property (
    $rose(done_oe_n) |-> chain_enable_out_n == $past(sync_q[ipus_pkg::IN_CHAIN]))
    else $error("chain enable out not in step with done");

  // indicator rises only after the done line was seen high
  a_user_after_done: assert property (
    $rose(user_mode_ind) |-> $past(done_in, 3) && !done_oe_n == 1'b0)
    else $error("user-mode indicator rose before done");

  // pull-ups are released in user mode
  a_pullup_release: assert property (
    state_r.st == ipus_pkg::ST_USER |-> !pullup_en)
    else $error("pull-ups still on in user mode");

  // disable input turns pull-ups off by the next edge
  a_pullup_off: assert property (
    HAS_PULLUP_DISABLE && sync_q[ipus_pkg::IN_PUD] |=> !pullup_en)
    else $error("pull-ups not disabled");

  // without the disable input pull-ups stay on until user mode
  a_pullup_fixed: assert property (
    !HAS_PULLUP_DISABLE && state_r.st != ipus_pkg::ST_USER |-> pullup_en)
    else $error("pull-ups off in a variant without disable");

  // every access phase is answered within one cycle
  a_apb_answer: assert property (
    psel && penable |-> ##[0:1] pready)
    else $error("apb access not answered");

endmodule
`default_nettype wire

// File: sim/ipus_board.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// board controller: drives the request pins and owns the line pull-ups
module ipus_board
(
  input wire logic pclk, // oscillator clock seen on the board
  input wire logic status_oe_n, // device pulls status low when 0
  input wire logic done_oe_n, // device pulls done low when 0
  input wire logic done2_oe_n, // second device pulls its done low when 0
  output logic reinit_req_n, // reinitialize request, active low
  output logic chain_enable_in_n, // chain enable towards the device
  output logic weak_pullup_disable, // pull-up disable pin
  output logic reset_delay_select, // long power-on select
  output logic status_line, // resolved status line
  output logic done_line, // resolved done line
  output logic done2_line // resolved done line of the second device
);
  // released lines float up to the pull-up level; the board never pulls them low
  assign status_line = status_oe_n ? 1'b1 : 1'b0;
  assign done_line = done_oe_n ? 1'b1 : 1'b0;
  assign done2_line = done2_oe_n ? 1'b1 : 1'b0;

  // idle levels: no request, chain enable held low
  initial
  begin
    reinit_req_n = 1'b1;
    chain_enable_in_n = 1'b0;
    weak_pullup_disable = 1'b0;
    reset_delay_select = 1'b0;
  end

  // pins change only just after a rising edge, so the device never sees a race
  task automatic drive(input logic rq_n, input logic ce_n, input logic pud, input logic sel);
    @(posedge pclk);
    reinit_req_n <= rq_n;
    chain_enable_in_n <= ce_n;
    weak_pullup_disable <= pud;
    reset_delay_select <= sel;
  endtask
endmodule
`default_nettype wire

// File: sim/ipus_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// bench top: short counts keep the run to a few hundred cycles
module ipus_sequencer_tb_top;
  localparam int P = 20;
  localparam int PL = 40;
  localparam int D = 50;
  localparam int INIT = ipus_pkg::INIT_CYC;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, status_oe_n, done_oe_n, done2_oe_n, chain_enable_out_n;
  logic user_mode_ind, pullup_en, pullup2_en, reg_reset, pll_init, io_enable;
  logic reinit_req_n, chain_enable_in_n, weak_pullup_disable, reset_delay_select;
  logic status_line, done_line, done2_line, err;
  logic status_out, done_out;
  logic [31:0] rd;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int at, t0;

  // clock and a count of edges since reset release
  always #25 pclk = ~pclk;
  always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;

  // =====================================================================
  // device under test, its delayed-mode twin without pull-up disable, board
  ipus_sequencer #(.DELAYED_MODE(1'b0), .POR_SHORT_CYC(P), .POR_LONG_CYC(PL),
    .DELAY_CYC(D)) i_ipus_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reinit_req_n(reinit_req_n),
    .chain_enable_in_n(chain_enable_in_n), .weak_pullup_disable(weak_pullup_disable),
    .reset_delay_select(reset_delay_select), .status_in(status_line), .status_out(status_out),
    .status_oe_n(status_oe_n), .done_in(done_line), .done_out(done_out), .done_oe_n(done_oe_n),
    .chain_enable_out_n(chain_enable_out_n), .user_mode_ind(user_mode_ind),
    .pullup_en(pullup_en), .reg_reset(reg_reset), .pll_init(pll_init),
    .io_enable(io_enable));
  ipus_sequencer #(.DELAYED_MODE(1'b1), .HAS_PULLUP_DISABLE(1'b0), .POR_SHORT_CYC(P),
    .POR_LONG_CYC(PL), .DELAY_CYC(D)) i_ipus_sequencer_dly (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .reinit_req_n(reinit_req_n),
    .chain_enable_in_n(chain_enable_in_n), .weak_pullup_disable(weak_pullup_disable),
    .reset_delay_select(reset_delay_select), .status_in(status_line), .status_out(),
    .status_oe_n(), .done_in(done2_line), .done_out(), .done_oe_n(done2_oe_n),
    .chain_enable_out_n(), .user_mode_ind(), .pullup_en(pullup2_en), .reg_reset(),
    .pll_init(), .io_enable());
  ipus_board i_ipus_board (.pclk(pclk), .status_oe_n(status_oe_n), .done_oe_n(done_oe_n),
    .done2_oe_n(done2_oe_n), .reinit_req_n(reinit_req_n),
    .chain_enable_in_n(chain_enable_in_n), .weak_pullup_disable(weak_pullup_disable),
    .reset_delay_select(reset_delay_select), .status_line(status_line),
    .done_line(done_line), .done2_line(done2_line));

  // =====================================================================
  // shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // reset held over four edges, left just after the release edge
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return status_oe_n;
      1: return done_oe_n;
      2: return user_mode_ind;
      default: return done2_oe_n;
    endcase
  endfunction

  // bounded wait for a level; reports the edge count where it was seen
  task automatic wait_for(input int k, input logic v, output int t);
    int n;
    n = 0;
    while (sig(k) !== v && n < 2000)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    // a level that never comes is a mismatch, not a silent pass
    if (n >= 2000)
      fails++;
    t = cyc;
  endtask

  // apb transfer: request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // =====================================================================
  // watchdog: the whole run needs well under 3000 cycles
  initial
  begin
    #(50 * 20000);
    fails++;
    final_report();
  end

  // =====================================================================
  // test sequence
  initial
  begin
    do_reset();
    chk("status_oe_n rst", status_oe_n, 0);
    chk("done_oe_n rst", done_oe_n, 0);
    chk("chain_out rst", chain_enable_out_n, 1);
    chk("user_ind rst", user_mode_ind, 0);
    chk("pullup rst", pullup_en, 1);
    chk("io_enable rst", io_enable, 0);
    chk("reg_reset rst", reg_reset, 1);
    chk("od level rst", {status_out, done_out}, 0);
    wait_for(0, 1'b1, at);
    chk("por end", at, P);
    chk("pll_init", pll_init, 1);
    chk("pullup init", pullup_en, 1);
    wait_for(1, 1'b1, at);
    chk("done release", at, P + INIT);
    chk("chain_out user", chain_enable_out_n, 0);
    chk("pullup user", pullup_en, 0);
    chk("reg_reset user", reg_reset, 0);
    chk("io_enable user", io_enable, 1);
    chk("pll_init user", pll_init, 0);
    chk("od level user", {status_out, done_out}, 0);
    wait_for(2, 1'b1, at);
    chk("user ind", at, P + INIT + 3);
    chk("pullup dly", pullup2_en, 1);
    wait_for(3, 1'b1, at);
    chk("done dly", at, P + D + INIT);
    // register access: status word, unmapped place, read-only write, restart
    apb(1'b0, ipus_pkg::ADDR_STATUS, 32'h00000000);
    chk("status reg", rd, 32'h000005B0);
    apb(1'b0, 8'h08, 32'h00000000);
    chk("unmapped err", {rd[30:0], err}, 32'h00000001);
    apb(1'b1, ipus_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    chk("ro write err", err, 0);
    apb(1'b1, ipus_pkg::ADDR_CTRL, 32'h00000001);
    wait_for(1, 1'b0, t0);
    wait_for(1, 1'b1, at);
    chk("sw restart init", at - t0, INIT);
    apb(1'b0, ipus_pkg::ADDR_CTRL, 32'h00000000);
    chk("ctrl cleared", rd, 0);
    // reinit pulse with stable supply: status falls and rises in bound
    i_ipus_board.drive(1'b0, 1'b0, 1'b0, 1'b0);
    #1;
    t0 = cyc;
    wait_for(0, 1'b0, at);
    chk("status fall", (at - t0) <= ipus_pkg::STATUS_FALL_CYC, 1);
    chk("done relow", done_oe_n, 0);
    repeat (10) @(posedge pclk);
    i_ipus_board.drive(1'b1, 1'b0, 1'b0, 1'b0);
    #1;
    t0 = cyc;
    wait_for(0, 1'b1, at);
    chk("status rise", (at - t0) <= ipus_pkg::STATUS_RISE_CYC, 1);
    wait_for(1, 1'b1, t0);
    chk("reinit done", t0 - at, INIT);
    // long select, pull-ups disabled, chain enable refused
    i_ipus_board.drive(1'b1, 1'b1, 1'b1, 1'b1);
    do_reset();
    repeat (4) @(posedge pclk);
    #1;
    chk("pullup disabled", pullup_en, 0);
    chk("pullup variant", pullup2_en, 1);
    wait_for(0, 1'b1, at);
    chk("por long", at, PL);
    wait_for(1, 1'b1, at);
    chk("chain refused", chain_enable_out_n, 1);
    // reinit held low past power-on postpones initialization
    i_ipus_board.drive(1'b0, 1'b0, 1'b0, 1'b0);
    do_reset();
    repeat (P + 30) @(posedge pclk);
    #1;
    chk("held status", status_oe_n, 0);
    chk("held done", done_oe_n, 0);
    i_ipus_board.drive(1'b1, 1'b0, 1'b0, 1'b0);
    #1;
    t0 = cyc;
    wait_for(1, 1'b1, at);
    chk("held release", at - t0, 3 + INIT);
    final_report();
  end
endmodule
`default_nettype wire
